// File: pkg/lcd_timing_pkg.sv
// Constants and types for the LCD frame and AC drive timing generator.
// Notes on behaviour
// - A 4-bit line_count_select field picks the duty, codes 0 to 9 giving 8 to 80 common rows in steps of eight.
// - The frame length in operating clocks follows the line count per table, with 1152 and 1280 for nine and ten lines.
// - In B-pattern mode the drive polarity flips once at the end of every complete frame.
// - In C-pattern mode the polarity flips after every ac_row_interval plus one raster rows, 1 to 32.
// - The operating clock comes from an external clock input or from the internal R-C oscillator.
`default_nettype none
package lcd_timing_pkg;
   localparam int unsigned LINE_SEL_W = 4;
   localparam int unsigned ROW_W = 7;
   localparam int unsigned NW_W = 5;
   localparam int unsigned FRAME_W = 11;
   localparam int unsigned PER_W = 8;
   localparam logic [LINE_SEL_W-1:0] LINE_SEL_MAX = 4'h9;
   localparam logic [ROW_W-1:0] ROWS_PER_LINE = 7'h08;

   typedef enum logic {AC_B_PATTERN, AC_C_PATTERN} ac_mode_t;

   typedef struct packed {
      logic [ROW_W-1:0] common_row;
      logic row_strobe;
      logic frame_strobe;
      logic polarity;
   } scan_out_t;

   // Frame length in operating clocks for each line count code.
   function automatic logic [FRAME_W-1:0] frame_clocks(input logic [LINE_SEL_W-1:0] sel);
      logic [FRAME_W-1:0] n;
      n = 11'h400;
      unique case (sel)
         4'h0: n = 11'h400;
         4'h1: n = 11'h400;
         4'h2: n = 11'h408;
         4'h3: n = 11'h400;
         4'h4: n = 11'h410;
         4'h5: n = 11'h3f0;
         4'h6: n = 11'h3f0;
         4'h7: n = 11'h400;
         4'h8: n = 11'h480;
         4'h9: n = 11'h500;
         default: n = 11'h400;
      endcase
      return n;
   endfunction

   // Number of driven common rows; out-of-range codes clamp to ten lines.
   function automatic logic [ROW_W-1:0] row_count(input logic [LINE_SEL_W-1:0] sel);
      logic [LINE_SEL_W-1:0] s;
      s = (sel > LINE_SEL_MAX) ? LINE_SEL_MAX : sel;
      return ROW_W'((ROW_W'(s) + 7'h01) * ROWS_PER_LINE);
   endfunction
endpackage
`default_nettype wire

// File: hdl/lcd_frame_ac_drive_timing.sv
// Frame, common-row scan and AC polarity generator of the LCD driver.
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_ac_drive_timing
   import lcd_timing_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_osc_clk_tick,
   input wire logic i_ext_clk_tick,
   input wire logic i_ext_clk_sel,
   input wire logic [LINE_SEL_W-1:0] i_line_count_select,
   input wire ac_mode_t i_ac_mode,
   input wire logic [NW_W-1:0] i_ac_row_interval,
   output logic [ROW_W-1:0] o_common_row,
   output logic o_row_strobe,
   output logic o_frame_strobe,
   output logic o_polarity
);

   // Operating clock and the settings that shape one frame.
   logic op_tick;
   logic [FRAME_W-1:0] frame_len;
   logic [FRAME_W-1:0] frame_last;
   logic [ROW_W-1:0] rows;
   logic [ROW_W-1:0] row_last;
   logic [PER_W-1:0] period;
   logic [PER_W-1:0] period_last;

   // Terminal counts decoded from the counters.
   logic frame_hit;
   logic period_hit;
   logic row_more;
   logic end_frame;
   logic end_row;
   logic scan_step;
   logic ac_hit;
   logic c_mode;

   // Counters.
   logic [FRAME_W-1:0] frame_cnt_ff;
   logic [PER_W-1:0] per_cnt_ff;
   logic [NW_W-1:0] ac_cnt_ff;

   // Output flops, gathered into one struct on the way to the pins.
   logic [ROW_W-1:0] common_row_ff;
   logic row_strobe_ff;
   logic frame_strobe_ff;
   logic polarity_ff;
   scan_out_t scan;

   // Operating clock is an enable tick from the chosen source.
   assign op_tick = i_ext_clk_sel ? i_ext_clk_tick : i_osc_clk_tick;

   assign frame_len = frame_clocks(i_line_count_select);
   assign frame_last = frame_len - 11'h001;
   assign rows = row_count(i_line_count_select);
   assign row_last = rows - 7'h01;

   // Integer division truncates; any remainder clocks stretch the last row.
   assign period = PER_W'(frame_len / FRAME_W'(rows));
   assign period_last = period - 8'h01;

   // Compares use >= so a setting changed mid-frame still ends the frame.
   assign frame_hit = frame_cnt_ff >= frame_last;
   assign period_hit = per_cnt_ff >= period_last;
   assign row_more = common_row_ff < row_last;

   assign end_frame = op_tick && frame_hit;
   assign end_row = op_tick && period_hit && row_more;
   assign scan_step = end_row || end_frame;

   assign c_mode = i_ac_mode == AC_C_PATTERN;
   assign ac_hit = ac_cnt_ff >= i_ac_row_interval;

   // Frame counter counts operating clocks and wraps at the frame length.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         frame_cnt_ff <= '0;
      end else if (end_frame) begin
         frame_cnt_ff <= '0;
      end else if (op_tick) begin
         frame_cnt_ff <= frame_cnt_ff + 11'h001;
      end
   end

   // Row period counter restarts on every row end, frame end included.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         per_cnt_ff <= '0;
      end else if (scan_step) begin
         per_cnt_ff <= '0;
      end else if (op_tick) begin
         per_cnt_ff <= per_cnt_ff + 8'h01;
      end
   end

   // Common scan steps once per period and wraps at frame end.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         common_row_ff <= '0;
      end else if (end_frame) begin
         common_row_ff <= '0;
      end else if (end_row) begin
         common_row_ff <= common_row_ff + 7'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         row_strobe_ff <= 1'b0;
      end else begin
         row_strobe_ff <= scan_step;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         frame_strobe_ff <= 1'b0;
      end else begin
         frame_strobe_ff <= end_frame;
      end
   end

   // B-pattern keeps the raster counter clear so a switch starts a fresh interval.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ac_cnt_ff <= '0;
      end else if (!c_mode) begin
         ac_cnt_ff <= '0;
      end else if (scan_step && ac_hit) begin
         ac_cnt_ff <= '0;
      end else if (scan_step) begin
         ac_cnt_ff <= ac_cnt_ff + 5'h01;
      end
   end

   // Frame end counts as a row end in C-pattern, so the last row of a frame is not lost.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         polarity_ff <= 1'b0;
      end else if (!c_mode && end_frame) begin
         polarity_ff <= ~polarity_ff;
      end else if (c_mode && scan_step && ac_hit) begin
         polarity_ff <= ~polarity_ff;
      end
   end

   assign scan.common_row = common_row_ff;
   assign scan.row_strobe = row_strobe_ff;
   assign scan.frame_strobe = frame_strobe_ff;
   assign scan.polarity = polarity_ff;

   assign o_common_row = scan.common_row;
   assign o_row_strobe = scan.row_strobe;
   assign o_frame_strobe = scan.frame_strobe;
   assign o_polarity = scan.polarity;
endmodule
`default_nettype wire

// File: verif/lcd_timing_checker.sv
// Port assertions for the LCD timing generator.
`timescale 1ns/1ps
`default_nettype none
module lcd_timing_checker
   import lcd_timing_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_osc_clk_tick,
   input wire logic i_ext_clk_tick,
   input wire logic [LINE_SEL_W-1:0] i_line_count_select,
   input wire ac_mode_t i_ac_mode,
   input wire logic [ROW_W-1:0] o_common_row,
   input wire logic o_row_strobe,
   input wire logic o_frame_strobe,
   input wire logic o_polarity
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_frame_wrap: assert property (o_frame_strobe |-> o_row_strobe && !o_common_row)
      else $error("no wrap");
   a_row_step: assert property (o_row_strobe && !o_frame_strobe |->
      o_common_row == $past(o_common_row) + 7'h01) else $error("bad step");
   a_row_limit: assert property ((o_common_row >> 3) <= i_line_count_select)
      else $error("row range");
   a_b_flip: assert property (i_ac_mode == AC_B_PATTERN && o_frame_strobe |->
      o_polarity != $past(o_polarity)) else $error("no flip");
   a_b_hold: assert property (i_ac_mode == AC_B_PATTERN && !o_frame_strobe |->
      $stable(o_polarity)) else $error("stray flip in frame");
   a_c_hold: assert property (i_ac_mode == AC_C_PATTERN && !o_row_strobe |->
      $stable(o_polarity)) else $error("stray flip");
   a_tick_cause: assert property (!$past(i_osc_clk_tick) && !$past(i_ext_clk_tick) |->
      !o_row_strobe) else $error("no tick");
endmodule
`default_nettype wire

// File: verif/lcd_panel_model.sv
// Panel model that counts the common rows ended within the frame.
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_row,
   input wire logic i_frame,
   output logic [6:0] o_row_count
);
   // Restarts at frame end so one frame's duty can be read back.
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_row_count <= 7'h00;
      end else if (i_frame) begin
         o_row_count <= 7'h00;
      end else begin
         o_row_count <= o_row_count + 7'(i_row);
      end
   end
endmodule
`default_nettype wire

// File: verif/lcd_frame_ac_drive_timing_bench.sv
// Self-checking bench for the LCD timing generator.
`timescale 1ns/1ps
`default_nettype none
module lcd_frame_ac_drive_timing_bench;
   import lcd_timing_pkg::*;
   logic i_clk = 1'h0, i_arst_n = 1'h0, i_osc_clk_tick = 1'h1, i_ext_clk_tick = 1'h0;
   logic i_ext_clk_sel = 1'h0, o_row_strobe, o_frame_strobe, o_polarity;
   logic [3:0] i_line_count_select = 4'h0;
   logic [4:0] i_ac_row_interval = 5'h02;
   logic [6:0] o_common_row, o_row_count;
   ac_mode_t i_ac_mode = AC_B_PATTERN;
   int n_mismatch = 0, n_compared = 0;
   always #10 i_clk = ~i_clk;
   lcd_frame_ac_drive_timing u_dut (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_osc_clk_tick(i_osc_clk_tick),
      .i_ext_clk_tick(i_ext_clk_tick),
      .i_ext_clk_sel(i_ext_clk_sel),
      .i_line_count_select(i_line_count_select),
      .i_ac_mode(i_ac_mode),
      .i_ac_row_interval(i_ac_row_interval),
      .o_common_row(o_common_row),
      .o_row_strobe(o_row_strobe),
      .o_frame_strobe(o_frame_strobe),
      .o_polarity(o_polarity)
   );
   lcd_panel_model u_panel (.i_clk, .i_arst_n, .i_row(o_row_strobe), .i_frame(o_frame_strobe),
      .o_row_count);
   task automatic chk(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: %h %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Row waits toggle the oscillator tick so idle cycles occur between ticks.
   task automatic wait_end(input logic f, output int n);
      n = 0;
      do begin
         @(negedge i_clk);
         i_osc_clk_tick = !i_ext_clk_sel && (f || !i_osc_clk_tick);
         n++;
      end while ((f ? o_frame_strobe : o_row_strobe) !== 1'h1 && n < 3000);
      if (n >= 3000) n_mismatch++;
   endtask
   task automatic frame_lengths;
      int len[10] = '{1024, 1024, 1032, 1024, 1040, 1008, 1008, 1024, 1152, 1280};
      int n;
      logic prev;
      wait_end(1'h1, n);
      for (int c = 0; c < 10; c++) begin
         i_line_count_select = 4'(c);
         i_ext_clk_sel = c[0];
         i_ext_clk_tick = c[0];
         i_osc_clk_tick = !c[0];
         prev = o_polarity;
         wait_end(1'h1, n);
         chk(16'(n), 16'(len[c]));
         chk(16'(o_polarity), 16'(!prev));
         chk(16'(o_row_count) + 16'h1, 16'(c * 8 + 8));
      end
   endtask
   task automatic c_pattern;
      int n, flips = 0;
      logic prev;
      i_ac_mode = AC_C_PATTERN;
      i_line_count_select = 4'h0;
      i_ext_clk_sel = 1'h0;
      i_ext_clk_tick = 1'h0;
      prev = o_polarity;
      for (int r = 0; r < 24; r++) begin
         wait_end(1'h0, n);
         flips += int'(o_polarity !== prev);
         prev = o_polarity;
      end
      chk(16'(flips), 16'h8);
   endtask
   initial begin
      repeat (3) @(negedge i_clk);
      i_arst_n = 1'h1;
      frame_lengths;
      c_pattern;
      test_done;
   end
   initial begin
      #1000000;
      n_mismatch++;
      test_done;
   end
endmodule
bind lcd_frame_ac_drive_timing lcd_timing_checker u_chk (.*);
`default_nettype wire
